// [hw/swr_pkg.sv]
// shared constants for the serial word repeater
package swr_pkg;
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned REF_PERIOD_NS = 1000;
	localparam int unsigned REF_DIV = REF_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned PULSE_NS = 1000;
	localparam int unsigned PULSE_CYCLES = PULSE_NS / CLK_PERIOD_NS;
	localparam int unsigned WORD_BITS = 32;
	localparam logic [6:0] HI_BIT_TICKS = 7'h0a;
	localparam logic [6:0] LO_BIT_TICKS = 7'h50;
	localparam logic [2:0] GAP_BITS = 3'h4;
	localparam logic [1:0] IDLE_BITS = 2'h2;
	localparam int unsigned LABEL_LSB = 0;
	localparam int unsigned LABEL_W = 8;
	localparam int unsigned SRC_DST_LSB = 8;
	localparam int unsigned SRC_DST_W = 2;
	localparam int unsigned SENSOR_LSB = 10;
	localparam int unsigned SENSOR_W = 16;
	localparam int unsigned PARITY_IDX = 31;
	localparam int unsigned FIFO_DEPTH = 8;
	typedef enum logic [1:0] {
		SWR_TX_IDLE = 2'b00,
		SWR_TX_HIGH = 2'b01,
		SWR_TX_NULL = 2'b11,
		SWR_TX_GAP = 2'b10
	} swr_tx_state_t;

	// bit period in 1 MHz ticks for a rate select
	function automatic logic [6:0] swr_bit_ticks(input logic high_speed);
		swr_bit_ticks = high_speed ? HI_BIT_TICKS : LO_BIT_TICKS;
	endfunction

	// value that makes bits 1..31 plus it odd
	function automatic logic swr_odd_bit(input logic [30:0] bits);
		swr_odd_bit = ~(^bits);
	endfunction
endpackage

// [hw/swr_fifo.sv]
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module swr_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic i_clock, // system clock
	input wire logic i_sys_rst, // sync reset, high
	input wire logic i_in_valid, // write request
	output logic o_in_ready, // room for a word
	input wire logic [WIDTH-1:0] i_in_data, // write word
	output logic o_out_valid, // word available
	input wire logic i_out_ready, // reader takes word
	output logic [WIDTH-1:0] o_out_data // head word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	// handshakes on both sides
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;
	assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign o_out_valid = (cnt_q != '0);
	assign o_out_data = mem_q[rd_q];

	// storage
	always_ff @(posedge i_clock) begin
		if (push) begin
			mem_q[wr_q] <= i_in_data;
		end
	end

	// pointers and fill level
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule

// [hw/swr_top.sv]
// serial word repeater: receiver, launch trigger, fifo and transmitter
// How it works
// - receive and transmit timing both come from one shared 1 MHz tick.
// - receiver turns each serial word into 32 parallel bits for transmitter.
// - optional label and source/destination filter decides which words go on.
// - receive and transmit each have their own rate select.
// - after a valid word, parallel outputs update, then word flag rises.
// - rising word flag fires one 1 us launch strobe.
// - each launch strobe sends exactly one 32-bit word from parallel inputs.
// - parity check on and odd parity gives bit32 output 0.
// - parity check on and even parity gives bit32 one, data still shown.
// - parity check on and parity failure holds trigger cleared, nothing resent.
// - parity check off: bits 1-31 resent as is, transmitter makes odd bit32.
// - sixteen inverting sensor inputs drive outgoing bits 26..11.
// - sensor inputs fed from inverted outputs; other links use true polarity.
`timescale 1ns/10ps
module swr_top
	import swr_pkg::*;
(
	input wire logic i_clock, // 200 MHz system clock
	input wire logic i_sys_rst, // sync reset, high
	input wire logic i_rx_line_one, // line receiver one level
	input wire logic i_rx_line_zero, // line receiver zero level
	input wire logic i_rx_high_speed, // receive rate select
	input wire logic i_tx_high_speed, // transmit rate select
	input wire logic i_label_filter_en, // label filter on
	input wire logic [LABEL_W-1:0] i_label_match, // wanted label
	input wire logic i_src_dst_filter_en, // source/destination filter on
	input wire logic [SRC_DST_W-1:0] i_src_dst_match, // wanted source_destination_bits
	input wire logic i_parity_check_en, // parity checking on
	output logic [WORD_BITS-1:0] o_rx_word, // parallel word, bit1 at 0
	output logic [WORD_BITS-1:0] o_inverted_bit_outputs, // complement of word
	output logic o_parity_result_inverted, // complement of bit32 output
	output logic o_word_received, // word received flag
	output logic o_transmit_launch_strobe, // 1 us launch pulse
	output logic o_tx_line_one, // transmit one level
	output logic o_tx_line_zero, // transmit zero level
	output logic o_tx_busy // word on the line
);
	// 1 MHz reference tick
	logic [7:0] ref_cnt_q;
	logic ref_tick_q;
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			ref_cnt_q <= '0;
			ref_tick_q <= 1'b0;
		end else begin
			ref_tick_q <= (ref_cnt_q == 8'(REF_DIV - 1));
			ref_cnt_q <= (ref_cnt_q == 8'(REF_DIV - 1)) ? '0 : ref_cnt_q + 1'b1;
		end
	end

	// line input synchronisers
	logic [1:0] one_s_q;
	logic [1:0] zero_s_q;
	logic one_d1_q;
	logic zero_d1_q;
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			one_s_q <= '0;
			zero_s_q <= '0;
			one_d1_q <= 1'b0;
			zero_d1_q <= 1'b0;
		end else begin
			one_s_q <= {one_s_q[0], i_rx_line_one};
			zero_s_q <= {zero_s_q[0], i_rx_line_zero};
			one_d1_q <= one_s_q[1];
			zero_d1_q <= zero_s_q[1];
		end
	end
	logic one_rise;
	logic zero_rise;
	assign one_rise = one_s_q[1] && !one_d1_q;
	assign zero_rise = zero_s_q[1] && !zero_d1_q;

	// deserialiser with idle timeout on the 1 MHz tick
	logic [WORD_BITS-1:0] shift_q;
	logic [5:0] bit_cnt_q;
	logic [8:0] idle_q;
	logic word_done_q;
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			shift_q <= '0;
			bit_cnt_q <= '0;
			idle_q <= '0;
			word_done_q <= 1'b0;
		end else begin
			word_done_q <= 1'b0;
			if (one_rise || zero_rise) begin
				shift_q <= {one_rise, shift_q[WORD_BITS-1:1]};
				idle_q <= '0;
				if (bit_cnt_q == 6'(WORD_BITS - 1)) begin
					bit_cnt_q <= '0;
					word_done_q <= 1'b1;
				end else begin
					bit_cnt_q <= bit_cnt_q + 1'b1;
				end
			end else if (ref_tick_q) begin
				if (idle_q >= 9'({IDLE_BITS, 7'h00} >> 7) * 9'(swr_bit_ticks(i_rx_high_speed))) begin
					bit_cnt_q <= '0;
				end else begin
					idle_q <= idle_q + 1'b1;
				end
			end
		end
	end

	// filter on label and source/destination bits
	logic pass;
	logic par_err;
	assign pass = (!i_label_filter_en || shift_q[LABEL_LSB +: LABEL_W] == i_label_match)
		&& (!i_src_dst_filter_en
		|| shift_q[SRC_DST_LSB +: SRC_DST_W] == i_src_dst_match);
	assign par_err = !(^shift_q);

	// present word, then raise the flag one cycle later
	logic present_q;
	logic flag_q;
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			o_rx_word <= '0;
			o_inverted_bit_outputs <= '1;
			o_parity_result_inverted <= 1'b1;
			present_q <= 1'b0;
			flag_q <= 1'b0;
		end else begin
			present_q <= word_done_q && pass;
			if (word_done_q && pass) begin
				o_rx_word[PARITY_IDX-1:0] <= shift_q[PARITY_IDX-1:0];
				o_inverted_bit_outputs[PARITY_IDX-1:0] <= ~shift_q[PARITY_IDX-1:0];
				if (i_parity_check_en) begin
					o_rx_word[PARITY_IDX] <= par_err;
					o_inverted_bit_outputs[PARITY_IDX] <= !par_err;
					o_parity_result_inverted <= !par_err;
				end else begin
					o_rx_word[PARITY_IDX] <= shift_q[PARITY_IDX];
					o_inverted_bit_outputs[PARITY_IDX] <= !shift_q[PARITY_IDX];
					o_parity_result_inverted <= !shift_q[PARITY_IDX];
				end
				flag_q <= 1'b0;
			end else if (present_q) begin
				flag_q <= 1'b1;
			end
		end
	end
	assign o_word_received = flag_q;

	// trigger stage: edge detect, parity clear, 1 us pulse
	logic flag_d1_q;
	logic pend_q;
	logic [7:0] pulse_cnt_q;
	logic fifo_in_ready;
	logic launch;
	logic parity_clear;
	assign parity_clear = i_parity_check_en && !o_parity_result_inverted;
	assign launch = pend_q && !o_transmit_launch_strobe && fifo_in_ready && !parity_clear;
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			flag_d1_q <= 1'b0;
			pend_q <= 1'b0;
			pulse_cnt_q <= '0;
			o_transmit_launch_strobe <= 1'b0;
		end else begin
			flag_d1_q <= flag_q;
			if (flag_q && !flag_d1_q) begin
				pend_q <= 1'b1;
			end else if (launch || parity_clear) begin
				pend_q <= 1'b0;
			end
			if (launch) begin
				o_transmit_launch_strobe <= 1'b1;
				pulse_cnt_q <= '0;
			end else if (o_transmit_launch_strobe) begin
				if (pulse_cnt_q == 8'(PULSE_CYCLES - 1)) begin
					o_transmit_launch_strobe <= 1'b0;
				end else begin
					pulse_cnt_q <= pulse_cnt_q + 1'b1;
				end
			end
		end
	end

	// transmit parallel inputs: sensor inputs invert again
	logic [WORD_BITS-1:0] tx_word;
	always_comb begin
		tx_word = o_rx_word;
		tx_word[SENSOR_LSB +: SENSOR_W] = ~o_inverted_bit_outputs[SENSOR_LSB +: SENSOR_W];
		tx_word[PARITY_IDX] = swr_odd_bit(tx_word[PARITY_IDX-1:0]);
	end

	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [WORD_BITS-1:0] fifo_out_data;
	swr_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) swr_fifo_inst (
		.i_clock(i_clock),
		.i_sys_rst(i_sys_rst),
		.i_in_valid(launch),
		.o_in_ready(fifo_in_ready),
		.i_in_data(tx_word),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(fifo_out_ready),
		.o_out_data(fifo_out_data)
	);

	// transmitter: return to zero, half bit high, half null, then gap
	swr_tx_state_t tx_state_q;
	logic [WORD_BITS-1:0] tx_shift_q;
	logic [5:0] tx_bits_q;
	logic [6:0] tx_ticks_q;
	logic [6:0] tx_period_q;
	assign fifo_out_ready = (tx_state_q == SWR_TX_IDLE) && ref_tick_q;
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			tx_state_q <= SWR_TX_IDLE;
			tx_shift_q <= '0;
			tx_bits_q <= '0;
			tx_ticks_q <= '0;
			tx_period_q <= HI_BIT_TICKS;
		end else begin
			case (tx_state_q)
				SWR_TX_IDLE: begin
					if (fifo_out_valid && ref_tick_q) begin
						tx_shift_q <= fifo_out_data;
						tx_period_q <= swr_bit_ticks(i_tx_high_speed);
						tx_bits_q <= '0;
						tx_ticks_q <= '0;
						tx_state_q <= SWR_TX_HIGH;
					end
				end
				SWR_TX_HIGH: begin
					if (ref_tick_q) begin
						if (tx_ticks_q == (tx_period_q >> 1) - 7'h01) begin
							tx_state_q <= SWR_TX_NULL;
						end
						tx_ticks_q <= tx_ticks_q + 1'b1;
					end
				end
				SWR_TX_NULL: begin
					if (ref_tick_q) begin
						if (tx_ticks_q == tx_period_q - 7'h01) begin
							tx_ticks_q <= '0;
							tx_shift_q <= tx_shift_q >> 1;
							if (tx_bits_q == 6'(WORD_BITS - 1)) begin
								tx_bits_q <= '0;
								tx_state_q <= SWR_TX_GAP;
							end else begin
								tx_bits_q <= tx_bits_q + 1'b1;
								tx_state_q <= SWR_TX_HIGH;
							end
						end else begin
							tx_ticks_q <= tx_ticks_q + 1'b1;
						end
					end
				end
				SWR_TX_GAP: begin
					if (ref_tick_q) begin
						if (tx_ticks_q == tx_period_q - 7'h01) begin
							tx_ticks_q <= '0;
							if (tx_bits_q == 6'(GAP_BITS - 1)) begin
								tx_state_q <= SWR_TX_IDLE;
							end else begin
								tx_bits_q <= tx_bits_q + 1'b1;
							end
						end else begin
							tx_ticks_q <= tx_ticks_q + 1'b1;
						end
					end
				end
				default: tx_state_q <= SWR_TX_IDLE;
			endcase
		end
	end

	// registered line drivers
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			o_tx_line_one <= 1'b0;
			o_tx_line_zero <= 1'b0;
			o_tx_busy <= 1'b0;
		end else begin
			o_tx_line_one <= (tx_state_q == SWR_TX_HIGH) && tx_shift_q[0];
			o_tx_line_zero <= (tx_state_q == SWR_TX_HIGH) && !tx_shift_q[0];
			o_tx_busy <= (tx_state_q != SWR_TX_IDLE);
		end
	end

	// checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);

	logic [7:0] hi_cnt_q;
	always_ff @(posedge i_clock) begin
		if (i_sys_rst || !o_transmit_launch_strobe) begin
			hi_cnt_q <= '0;
		end else begin
			hi_cnt_q <= hi_cnt_q + 1'b1;
		end
	end

	sequence s_word_in;
		word_done_q && pass ##1 present_q;
	endsequence

	a_ref_tick_gap: assert property (ref_tick_q |=> !ref_tick_q[*8])
		else $error("reference tick too frequent");
	a_word_flag_order: assert property (s_word_in |=> flag_q)
		else $error("flag did not follow word");
	a_strobe_width: assert property ($fell(o_transmit_launch_strobe)
		|-> $past(hi_cnt_q) == 8'(PULSE_CYCLES - 1))
		else $error("launch pulse width wrong");
	a_rearm_edge: assert property ($rose(o_transmit_launch_strobe)
		|-> $past(pend_q))
		else $error("pulse without a flag edge");
	a_parity_block: assert property (parity_clear && !(flag_q && !flag_d1_q)
		|-> !launch ##1 !pend_q)
		else $error("launch despite parity failure");
	a_parity_out: assert property (present_q && i_parity_check_en
		|-> o_rx_word[PARITY_IDX] == !(^{o_rx_word[PARITY_IDX-1:0], $past(shift_q[PARITY_IDX])}))
		else $error("bit32 output wrong");
	a_one_push: assert property (launch |=> !launch[*8])
		else $error("more than one word per strobe");
	a_sensor_cancel: assert property (launch
		|-> tx_word[PARITY_IDX-1:0] == o_rx_word[PARITY_IDX-1:0])
		else $error("sensor bits not restored");
	a_tx_odd: assert property (tx_state_q == SWR_TX_IDLE && fifo_out_valid && ref_tick_q
		|=> ^tx_shift_q)
		else $error("outgoing word not odd parity");
	a_filter_pass: assert property (present_q && i_label_filter_en
		|-> o_rx_word[LABEL_LSB +: LABEL_W] == i_label_match)
		else $error("filtered label passed");
endmodule

// [testbench/swr_far_end.sv]
// far-side model: serial word source and regenerated word sink
`timescale 1ns/10ps
module swr_far_end (
	input wire logic i_clock, // system clock
	input wire logic i_tx_line_one, // repeater one level
	input wire logic i_tx_line_zero, // repeater zero level
	output logic o_line_one, // source one level
	output logic o_line_zero, // source zero level
	output logic [31:0] o_sink_word, // first regenerated word
	output logic [5:0] o_sink_bits, // bits caught so far
	output logic [11:0] o_first_high // high cycles of first bit
);
	logic prev_q;
	logic hi;
	assign hi = i_tx_line_one | i_tx_line_zero;
	initial begin
		o_line_one = 1'b0;
		o_line_zero = 1'b0;
		o_sink_word = 32'h0;
		o_sink_bits = 6'h0;
		o_first_high = 12'h0;
		prev_q = 1'b0;
	end
	// source: first n bits, bit1 first, short pulse then null with both lines low
	task automatic send_word(input logic [31:0] w, input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge i_clock);
			o_line_one = w[i];
			o_line_zero = ~w[i];
			repeat (4) @(negedge i_clock);
			o_line_one = 1'b0;
			o_line_zero = 1'b0;
			repeat (3) @(negedge i_clock);
		end
	endtask
	// sink: one bit per rising pulse, first word only
	always @(posedge i_clock) begin
		prev_q <= hi;
		if (hi && !prev_q && o_sink_bits < 6'h20) begin
			o_sink_word[o_sink_bits] <= i_tx_line_one;
			o_sink_bits <= o_sink_bits + 6'h1;
		end
		if (hi && (o_sink_bits == 6'h0 || (o_sink_bits == 6'h1 && prev_q)))
			o_first_high <= o_first_high + 12'h1;
	end
endmodule

// [testbench/tb_serial_avionics_word_repeater.sv]
// testbench for the serial word repeater
`timescale 1ns/10ps
module tb_serial_avionics_word_repeater;
	import swr_pkg::*;
	logic i_clock = 1'b0;
	logic i_sys_rst = 1'b1;
	logic rx_one, rx_zero, tx_one, tx_zero;
	logic i_label_filter_en = 1'b0, i_src_dst_filter_en = 1'b0, i_parity_check_en = 1'b0;
	logic i_rx_high_speed = 1'b1, i_tx_high_speed = 1'b1;
	logic [7:0] i_label_match = 8'h3c;
	logic [1:0] i_src_dst_match = 2'h2;
	logic [31:0] o_rx_word, o_inv, sink_word;
	logic o_par_inv, o_flag, o_strobe, o_busy, flag_prev = 1'b0, strb_prev = 1'b0;
	logic [5:0] sink_bits;
	logic [11:0] first_high;
	logic [31:0] flag_rises = 32'h0, strb_rises = 32'h0, strb_len = 32'h0, r0, s0;
	logic [31:0] hi_run = 32'h0, last_high = 32'h0;
	int failures = 0;
	int checks = 0;
	always #2.5 i_clock = ~i_clock;
	swr_top swr_top_inst (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_rx_line_one(rx_one),
		.i_rx_line_zero(rx_zero), .i_rx_high_speed(i_rx_high_speed),
		.i_tx_high_speed(i_tx_high_speed),
		.i_label_filter_en(i_label_filter_en), .i_label_match(i_label_match),
		.i_src_dst_filter_en(i_src_dst_filter_en), .i_src_dst_match(i_src_dst_match),
		.i_parity_check_en(i_parity_check_en), .o_rx_word(o_rx_word),
		.o_inverted_bit_outputs(o_inv), .o_parity_result_inverted(o_par_inv),
		.o_word_received(o_flag), .o_transmit_launch_strobe(o_strobe),
		.o_tx_line_one(tx_one), .o_tx_line_zero(tx_zero), .o_tx_busy(o_busy));
	swr_far_end swr_far_end_inst (.i_clock(i_clock), .i_tx_line_one(tx_one),
		.i_tx_line_zero(tx_zero), .o_line_one(rx_one), .o_line_zero(rx_zero),
		.o_sink_word(sink_word), .o_sink_bits(sink_bits), .o_first_high(first_high));
	// count flag rises, strobe pulses and strobe width
	always @(posedge i_clock) begin
		flag_prev <= o_flag;
		strb_prev <= o_strobe;
		if (o_flag === 1'b1 && !flag_prev) flag_rises <= flag_rises + 32'h1;
		if (o_strobe === 1'b1 && !strb_prev) strb_rises <= strb_rises + 32'h1;
		if (o_strobe === 1'b1) strb_len <= strb_prev ? strb_len + 32'h1 : 32'h1;
	end
	// length of the latest transmit pulse
	always @(posedge i_clock) begin
		if ((tx_one | tx_zero) === 1'b1) begin
			hi_run <= hi_run + 32'h1;
		end else if (hi_run != 32'h0) begin
			last_high <= hi_run;
			hi_run <= 32'h0;
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// send a word and give the receiver its fixed answer delay
	task automatic send(input logic [31:0] w);
		r0 = flag_rises;
		s0 = strb_rises;
		swr_far_end_inst.send_word(w, 32);
		repeat (10) @(negedge i_clock);
	endtask
	task automatic test_parity_bad();
		i_parity_check_en = 1'b1;
		send(32'h1234_5679);
		check(o_rx_word, 32'h9234_5679);
		check(o_inv, 32'h6dcb_a986);
		check({31'h0, o_par_inv}, 32'h0);
		check(flag_rises, r0 + 32'h1);
		repeat (300) @(negedge i_clock);
		check(strb_rises, s0);
		check({31'h0, o_busy}, 32'h0);
		$display("test parity_bad done");
	endtask
	task automatic test_filter();
		logic [31:0] w [2] = '{32'h0a5a_5a3d, 32'h0a5a_593c};
		i_label_filter_en = 1'b1;
		i_src_dst_filter_en = 1'b1;
		for (int i = 0; i < 2; i++) begin
			send(w[i]);
			check(flag_rises, r0);
			check(o_rx_word, 32'h9234_5679);
		end
		$display("test filter done");
	endtask
	task automatic test_launch();
		i_parity_check_en = 1'b0;
		send(32'h0a5a_5a3c);
		check(o_rx_word, 32'h0a5a_5a3c);
		check({31'h0, o_par_inv}, 32'h1);
		check(flag_rises, r0 + 32'h1);
		repeat (220) @(negedge i_clock);
		check(strb_rises, s0 + 32'h1);
		check(strb_len, 32'd200);
		$display("test launch done");
	endtask
	task automatic test_second();
		i_parity_check_en = 1'b1;
		send(32'h0b5a_5a3c);
		check(o_rx_word, 32'h0b5a_5a3c);
		check({31'h0, o_par_inv}, 32'h1);
		repeat (600) @(negedge i_clock);
		check(strb_rises, s0 + 32'h1);
		$display("test second done");
	endtask
	task automatic test_tx();
		for (int n = 0; n < 80000 && sink_bits !== 6'h20; n++) @(negedge i_clock);
		check({26'h0, sink_bits}, 32'h20);
		check({31'h0, o_busy}, 32'h1);
		check(sink_word, 32'h8a5a_5a3c);
		check({20'h0, first_high}, 32'd1000);
		check(strb_rises, 32'h2);
		$display("test tx done");
	endtask
	// receive idle timeout per rate, then slow transmit bit for the queued word
	task automatic test_rate();
		i_tx_high_speed = 1'b0;
		i_parity_check_en = 1'b1;
		swr_far_end_inst.send_word(32'h0000_001f, 5);
		repeat (5000) @(negedge i_clock);
		send(32'h0a5a_5a3c);
		check(flag_rises, r0 + 32'h1);
		check(o_rx_word, 32'h8a5a_5a3c);
		i_rx_high_speed = 1'b0;
		r0 = flag_rises;
		swr_far_end_inst.send_word(32'h0a5a_5a3c, 5);
		repeat (5000) @(negedge i_clock);
		swr_far_end_inst.send_word(32'h0a5a_5a3c >> 5, 27);
		repeat (10) @(negedge i_clock);
		check(flag_rises, r0 + 32'h1);
		check(o_rx_word, 32'h8a5a_5a3c);
		check(strb_rises, 32'h2);
		repeat (12000) @(negedge i_clock);
		check(last_high, 32'd8000);
		$display("test rate done");
	endtask
	task automatic test_done();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (2) @(negedge i_clock);
		i_sys_rst = 1'b0;
		test_parity_bad();
		test_filter();
		test_launch();
		test_second();
		test_tx();
		test_rate();
		test_done();
	end
	// watchdog sized for one high-speed word, one slow bit and receive tests
	initial begin
		#500000;
		failures++;
		test_done();
	end
endmodule
